// *** pkg/mcs_pkg.sv ***
package mcs_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] MCS_IDX_GLOBAL = 6'h0b;
  localparam logic [5:0] MCS_IDX_HOLDRUN = 6'h10;
  localparam logic [5:0] MCS_IDX_IDLEDLY = 6'h11;
  localparam logic [5:0] MCS_IDX_CTRL = 6'h1e;
  localparam logic [5:0] MCS_IDX_STATUS = 6'h1f;

  // field positions in hold_run_current_control
  localparam int MCS_HOLD_LSB = 0;
  localparam int MCS_RUN_LSB = 8;
  localparam int MCS_DOWN_DLY_LSB = 16;
  localparam int MCS_UP_DLY_LSB = 24;
  // field positions in the status register
  localparam int MCS_STAT_LVL_LSB = 0;
  localparam int MCS_STAT_STATE_LSB = 8;

  // reset values
  localparam logic [7:0] MCS_RST_GLOBAL = 8'h00;
  localparam logic [4:0] MCS_RST_HOLD = 5'h08;
  localparam logic [4:0] MCS_RST_RUN = 5'h1f;
  localparam logic [3:0] MCS_RST_DOWN_DLY = 4'h1;
  localparam logic [3:0] MCS_RST_UP_DLY = 4'h4;
  localparam logic [7:0] MCS_RST_IDLEDLY = 8'h0a;
  localparam logic MCS_RST_SHORT_SEL = 1'b0;

  // timing, in core clock cycles
  localparam int MCS_UP_STEP_CLKS = 512;
  localparam int MCS_DOWN_UNIT_CLKS = 262144;
  localparam int MCS_TMR_W = 28;

  // scale handling
  localparam logic [8:0] MCS_FULL_SCALE = 9'h100;
  localparam int MCS_CUR_W = 14;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_RUN_UP,
    ST_RUN,
    ST_IDLE_WAIT,
    ST_DOWN
  } mcs_state_t;

  typedef struct packed {
    logic [3:0] upDly;
    logic [3:0] downDly;
    logic [4:0] runLvl;
    logic [4:0] holdLvl;
  } mcs_hold_run_t;

  typedef struct packed {
    logic [MCS_CUR_W-1:0] coilCurrent;
    logic [4:0] level;
    logic freewheel;
    logic shortCoils;
  } mcs_drive_t;

endpackage : mcs_pkg

// *** rtl/mcs_step_timer.sv ***
`timescale 1ns/1ns
module mcs_step_timer
  import mcs_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic load,
  input wire logic [MCS_TMR_W-1:0] loadVal,
  // status
  output logic expire
);

  logic [MCS_TMR_W-1:0] cnt_q;
  logic [MCS_TMR_W-1:0] cnt_d;

  // reload wins, otherwise count down to zero and stop
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = loadVal;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

  // pulse on the last cycle of a loaded interval
  assign expire = ce && (cnt_q == MCS_TMR_W'(1));

endmodule : mcs_step_timer

// *** rtl/mcs_current_mult.sv ***
`timescale 1ns/1ns
module mcs_current_mult
  import mcs_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // operands
  input wire logic [4:0] level,
  input wire logic [7:0] globalScale,
  // result
  output logic [MCS_CUR_W-1:0] current
);

  logic [8:0] scaleEff;
  logic [MCS_CUR_W-1:0] current_d;
  logic [MCS_CUR_W-1:0] current_q;

  // zero means full scale; (level+1)/32 times scale/256
  always_comb begin
    scaleEff = (globalScale == 8'h00) ? MCS_FULL_SCALE : {1'b0, globalScale};
    // operands widened to the result so 32 x 256 cannot wrap
    current_d = ({9'h000, level} + 14'h0001) * {5'h00, scaleEff};
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      current_q <= '0;
    end else if (ce) begin
      current_q <= current_d;
    end
  end

  assign current = current_q;

endmodule : mcs_current_mult

// *** rtl/mcs_current_scaling.sv ***
// Our own choice: register access over Wishbone.
`timescale 1ns/1ns
module mcs_current_scaling
  import mcs_pkg::*;
#(
  parameter int DOWN_UNIT_CLKS = MCS_DOWN_UNIT_CLKS
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // motion status
  input wire logic standstill,
  input wire logic voltagePwmMode,
  // drive output
  output mcs_drive_t drive
);

  // register address match on the word index
  function automatic logic regHit(input logic [7:0] adr, input logic [5:0] idx);
    regHit = (adr[7:2] == idx);
  endfunction : regHit

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] mergeLanes(input logic [31:0] oldW,
                                             input logic [31:0] newW,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = oldW;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = newW[8*b +: 8];
      end
    end
    mergeLanes = res;
  endfunction : mergeLanes

  // pack the hold/run fields into their word
  function automatic logic [31:0] holdRunWord(input mcs_hold_run_t hr);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[MCS_HOLD_LSB +: 5] = hr.holdLvl;
    w[MCS_RUN_LSB +: 5] = hr.runLvl;
    w[MCS_DOWN_DLY_LSB +: 4] = hr.downDly;
    w[MCS_UP_DLY_LSB +: 4] = hr.upDly;
    holdRunWord = w;
  endfunction : holdRunWord

  // register file state
  logic [7:0] globalScale_q;
  logic [7:0] globalScale_d;
  mcs_hold_run_t holdRun_q;
  mcs_hold_run_t holdRun_d;
  logic [7:0] idleDelay_q;
  logic [7:0] idleDelay_d;
  logic shortSel_q;
  logic shortSel_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdData_q;
  logic [31:0] rdData_d;

  // power state
  mcs_state_t state_q;
  mcs_state_t state_d;
  logic [4:0] level_q;
  logic [4:0] level_d;
  logic freewheel_q;
  logic freewheel_d;
  logic shortCoils_q;
  logic shortCoils_d;

  // helpers
  logic busReq;
  logic wrEn;
  logic [31:0] wrHoldRun;
  logic [31:0] statusWord;
  logic motion;
  logic tmrLoad;
  logic [MCS_TMR_W-1:0] tmrVal;
  logic tmrExpire;
  logic [MCS_TMR_W-1:0] upStepVal;
  logic [MCS_TMR_W-1:0] downStepVal;
  logic [MCS_TMR_W-1:0] idleVal;
  logic [MCS_CUR_W-1:0] coilCurrent;

  // bus request, write commits on the edge that sees ack
  assign busReq = wb_cyc_i && wb_stb_i;
  assign wrEn = busReq && wb_we_i && ack_q;
  assign wrHoldRun = mergeLanes(holdRunWord(holdRun_q), wb_dat_i, wb_sel_i);

  // status word shows live level and power state
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[MCS_STAT_LVL_LSB +: 5] = level_q;
    statusWord[MCS_STAT_STATE_LSB +: 3] = state_q;
  end

  // register file next values and read data
  always_comb begin
    globalScale_d = globalScale_q;
    holdRun_d = holdRun_q;
    idleDelay_d = idleDelay_q;
    shortSel_d = shortSel_q;
    ack_d = busReq && !ack_q;
    rdData_d = rdData_q;
    if (wrEn) begin
      if (regHit(wb_adr_i, MCS_IDX_GLOBAL) && wb_sel_i[0]) begin
        globalScale_d = wb_dat_i[7:0];
      end
      if (regHit(wb_adr_i, MCS_IDX_HOLDRUN)) begin
        holdRun_d.holdLvl = wrHoldRun[MCS_HOLD_LSB +: 5];
        holdRun_d.runLvl = wrHoldRun[MCS_RUN_LSB +: 5];
        holdRun_d.downDly = wrHoldRun[MCS_DOWN_DLY_LSB +: 4];
        holdRun_d.upDly = wrHoldRun[MCS_UP_DLY_LSB +: 4];
      end
      if (regHit(wb_adr_i, MCS_IDX_IDLEDLY) && wb_sel_i[0]) begin
        idleDelay_d = wb_dat_i[7:0];
      end
      if (regHit(wb_adr_i, MCS_IDX_CTRL) && wb_sel_i[0]) begin
        shortSel_d = wb_dat_i[0];
      end
    end
    // read data captured as ack rises; unmapped reads return zero
    if (busReq && !ack_q) begin
      if (regHit(wb_adr_i, MCS_IDX_GLOBAL)) begin
        rdData_d = {24'h00_0000, globalScale_q};
      end else if (regHit(wb_adr_i, MCS_IDX_HOLDRUN)) begin
        rdData_d = holdRunWord(holdRun_q);
      end else if (regHit(wb_adr_i, MCS_IDX_IDLEDLY)) begin
        rdData_d = {24'h00_0000, idleDelay_q};
      end else if (regHit(wb_adr_i, MCS_IDX_CTRL)) begin
        rdData_d = {31'h0000_0000, shortSel_q};
      end else if (regHit(wb_adr_i, MCS_IDX_STATUS)) begin
        rdData_d = statusWord;
      end else begin
        rdData_d = 32'h0000_0000;
      end
    end
  end

  // register file flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      globalScale_q <= MCS_RST_GLOBAL;
      holdRun_q.holdLvl <= MCS_RST_HOLD;
      holdRun_q.runLvl <= MCS_RST_RUN;
      holdRun_q.downDly <= MCS_RST_DOWN_DLY;
      holdRun_q.upDly <= MCS_RST_UP_DLY;
      idleDelay_q <= MCS_RST_IDLEDLY;
      shortSel_q <= MCS_RST_SHORT_SEL;
      ack_q <= 1'b0;
      rdData_q <= 32'h0000_0000;
    end else if (ce) begin
      globalScale_q <= globalScale_d;
      holdRun_q <= holdRun_d;
      idleDelay_q <= idleDelay_d;
      shortSel_q <= shortSel_d;
      ack_q <= ack_d;
      rdData_q <= rdData_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdData_q;

  // step interval loads
  assign motion = !standstill;
  assign upStepVal = MCS_TMR_W'(holdRun_q.upDly * MCS_UP_STEP_CLKS);
  assign downStepVal = MCS_TMR_W'(holdRun_q.downDly * DOWN_UNIT_CLKS);
  assign idleVal = MCS_TMR_W'(idleDelay_q * DOWN_UNIT_CLKS);

  // shared interval timer; only one interval runs at a time
  mcs_step_timer u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .load(tmrLoad),
    .loadVal(tmrVal),
    .expire(tmrExpire)
  );

  // power state machine
  always_comb begin
    state_d = state_q;
    level_d = level_q;
    tmrLoad = 1'b0;
    tmrVal = '0;
    case (state_q)
      ST_HOLD: begin
        level_d = holdRun_q.holdLvl;
        if (motion) begin
          if (holdRun_q.upDly == 4'h0) begin
            level_d = holdRun_q.runLvl;
            state_d = ST_RUN;
          end else begin
            state_d = ST_RUN_UP;
            tmrLoad = 1'b1;
            tmrVal = upStepVal;
          end
        end
      end
      ST_RUN_UP: begin
        if (!motion) begin
          state_d = ST_IDLE_WAIT;
          tmrLoad = 1'b1;
          tmrVal = idleVal;
        end else if (level_q >= holdRun_q.runLvl) begin
          level_d = holdRun_q.runLvl;
          state_d = ST_RUN;
        end else if (tmrExpire) begin
          level_d = level_q + 5'h01;
          tmrLoad = 1'b1;
          tmrVal = upStepVal;
        end
      end
      ST_RUN: begin
        level_d = holdRun_q.runLvl;
        if (!motion) begin
          state_d = ST_IDLE_WAIT;
          tmrLoad = 1'b1;
          tmrVal = idleVal;
        end
      end
      ST_IDLE_WAIT: begin
        if (motion) begin
          level_d = holdRun_q.runLvl;
          state_d = ST_RUN;
        end else if (tmrExpire || idleDelay_q == 8'h00) begin
          if (holdRun_q.downDly == 4'h0 || level_q <= holdRun_q.holdLvl) begin
            level_d = holdRun_q.holdLvl;
            state_d = ST_HOLD;
          end else begin
            state_d = ST_DOWN;
            tmrLoad = 1'b1;
            tmrVal = downStepVal;
          end
        end
      end
      ST_DOWN: begin
        if (motion) begin
          level_d = holdRun_q.runLvl;
          state_d = ST_RUN;
        end else if (level_q <= holdRun_q.holdLvl) begin
          level_d = holdRun_q.holdLvl;
          state_d = ST_HOLD;
        end else if (tmrExpire) begin
          level_d = level_q - 5'h01;
          tmrLoad = 1'b1;
          tmrVal = downStepVal;
        end
      end
      default: begin
        state_d = ST_HOLD;
        level_d = holdRun_q.holdLvl;
      end
    endcase
  end

  // zero hold level in voltage-PWM standstill picks the coil treatment;
  // taken from the next state so it never outlives the hold level
  always_comb begin
    freewheel_d = 1'b0;
    shortCoils_d = 1'b0;
    if (voltagePwmMode && state_d == ST_HOLD && holdRun_q.holdLvl == 5'h00) begin
      freewheel_d = !shortSel_q;
      shortCoils_d = shortSel_q;
    end
  end

  // power state flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_HOLD;
      level_q <= MCS_RST_HOLD;
      freewheel_q <= 1'b0;
      shortCoils_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      level_q <= level_d;
      freewheel_q <= freewheel_d;
      shortCoils_q <= shortCoils_d;
    end
  end

  // scaled coil current
  mcs_current_mult u_mult (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .level(level_q),
    .globalScale(globalScale_q),
    .current(coilCurrent)
  );

  // drive bundle
  always_comb begin
    drive.coilCurrent = coilCurrent;
    drive.level = level_q;
    drive.freewheel = freewheel_q;
    drive.shortCoils = shortCoils_q;
  end

endmodule : mcs_current_scaling

// *** verification/mcs_current_scaling_asserts.sv ***
`timescale 1ns/1ns
module mcs_current_scaling_asserts
  import mcs_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // motion and drive
  input wire logic standstill,
  input wire logic voltagePwmMode,
  input wire mcs_drive_t drive
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [7:0] scale_q;
  logic [7:0] scale_d;
  // shadow of the global factor, committed at the ack edge
  always_comb begin
    scale_d = scale_q;
    if (ce && wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
        && wb_adr_i[7:2] == MCS_IDX_GLOBAL) begin
      scale_d = wb_dat_i[7:0];
    end
  end
  always_ff @(posedge core_clk) begin
    scale_q <= rst ? MCS_RST_GLOBAL : scale_d;
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  endsequence
  property p_ack_resp;
    s_req |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o && ce |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_mult;
    !$past(rst) && $past(ce) |-> drive.coilCurrent == ({9'h0, $past(drive.level)} + 14'h1)
      * (($past(scale_q) == 8'h00) ? 14'h100 : {6'h0, $past(scale_q)});
  endproperty
  a_mult: assert property (p_mult) else $error("coil current wrong");
  property p_wheel_lvl;
    drive.freewheel || drive.shortCoils |-> drive.level == 5'h00
      && !(drive.freewheel && drive.shortCoils);
  endproperty
  a_wheel_lvl: assert property (p_wheel_lvl) else $error("standstill mode bad");
  property p_wheel_pwm;
    !$past(voltagePwmMode) && !$past(rst) |-> !drive.freewheel && !drive.shortCoils;
  endproperty
  a_wheel_pwm: assert property (p_wheel_pwm) else $error("mode without pwm");
  property p_no_drop;
    !$past(rst) && !$past(standstill) && !$past(wb_ack_o) && !$past(wb_ack_o, 2)
      |-> drive.level >= $past(drive.level);
  endproperty
  a_no_drop: assert property (p_no_drop) else $error("drop in motion");
  property p_idle_hold;
    $rose(standstill) |=> $stable(drive.level);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("early power down");
endmodule : mcs_current_scaling_asserts

bind mcs_current_scaling mcs_current_scaling_asserts mcs_current_scaling_asserts_inst (
  .core_clk, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_ack_o, .standstill, .voltagePwmMode, .drive);

// *** verification/testbench.sv ***
`timescale 1ns/1ns
module testbench
  import mcs_pkg::*;
;
  typedef struct packed {logic [7:0] gs; logic [4:0] hold; logic [13:0] cur;} mcs_row_t;
  // factor, standstill level, expected coil current
  mcs_row_t rows [6] = '{'{8'h00, 5'h08, 14'h0900}, '{8'h00, 5'h1f, 14'h2000},
    '{8'h20, 5'h00, 14'h0020}, '{8'hff, 5'h1f, 14'h1fe0},
    '{8'h80, 5'h0f, 14'h0800}, '{8'hc8, 5'h10, 14'h0d48}};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatW = 32'h0;
  logic [31:0] wbDatR;
  logic wbAck;
  logic standstill = 1'b1;
  logic pwmMode = 1'b0;
  logic ce = 1'b1;
  logic [31:0] rd;
  mcs_drive_t drive;
  int num_errors = 0;
  int compares = 0;
  int t;
  mcs_current_scaling #(.DOWN_UNIT_CLKS(4)) mcs_current_scaling_inst (.core_clk(core_clk),
    .rst(rst), .ce(ce), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
    .wb_ack_o(wbAck), .standstill(standstill), .voltagePwmMode(pwmMode), .drive(drive));
  initial forever #4 core_clk = ~core_clk;
  // one classic cycle, held until ack
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatW <= dat;
    // only the watchdog ends a wait for ack
    do begin
      @(posedge core_clk);
    end while (wbAck !== 1'b1);
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask : bus
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic chk_gap(input string nm, input int exp, input int got);
    compares++;
    if (got != exp) begin
      num_errors++;
      $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_gap
  // cycles until the level reaches a value, bounded
  task automatic wait_lvl(input logic [4:0] lvl, input int lim, output int n);
    n = 0;
    while (drive.level !== lvl && n < lim) begin
      @(posedge core_clk);
      n++;
    end
  endtask : wait_lvl
  task automatic print_verdict();
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    // reset values and an unmapped place
    bus(1'b0, 8'h2c, 32'h0);
    chk("global", 32'h0, rd);
    bus(1'b0, 8'h40, 32'h0);
    chk("holdrun", 32'h04011f08, rd);
    bus(1'b0, 8'h44, 32'h0);
    chk("idle", 32'h0000000a, rd);
    bus(1'b1, 8'h20, 32'hffffffff);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("reset cur", 32'h900, {18'h0, drive.coilCurrent});
    // factor and level table, kept clear of 1 to 31
    foreach (rows[i]) begin
      bus(1'b1, 8'h2c, {24'h0, rows[i].gs});
      bus(1'b0, 8'h2c, 32'h0);
      chk("global rb", {24'h0, rows[i].gs}, rd);
      bus(1'b1, 8'h40, {16'h0401, 3'h7, 8'h0, rows[i].hold});
      wait_lvl(rows[i].hold, 5, t);
      @(posedge core_clk);
      chk("coil", {18'h0, rows[i].cur}, {18'h0, drive.coilCurrent});
    end
    // stepped power up from 12 to 16
    bus(1'b1, 8'h40, 32'h0102100c);
    bus(1'b1, 8'h44, 32'h3);
    standstill <= 1'b0;
    wait_lvl(5'd13, 1000, t);
    chk_gap("first up", 514, t);
    for (int l = 14; l <= 16; l++) begin
      wait_lvl(l[4:0], 1000, t);
      chk_gap("up gap", 512, t);
    end
    // idle wait, then steps down every 2*4 cycles
    standstill <= 1'b1;
    wait_lvl(5'd15, 100, t);
    chk("idle wait", 32'h1, {31'h0, t >= 12 && t <= 24});
    wait_lvl(5'd14, 100, t);
    chk_gap("down gap", 8, t);
    // motion in mid power down restores run at once
    standstill <= 1'b0;
    wait_lvl(5'd16, 3, t);
    chk("resume", 32'd16, {27'h0, drive.level});
    // status shows run state 2 and level 16
    bus(1'b0, 8'h7c, 32'h0);
    chk("status", 32'h00000210, rd);
    // zero delays: instant change both ways
    bus(1'b1, 8'h40, 32'h00001405);
    bus(1'b1, 8'h44, 32'h0);
    wait_lvl(5'd20, 3, t);
    chk("run level", 32'd20, {27'h0, drive.level});
    standstill <= 1'b1;
    wait_lvl(5'd5, 6, t);
    chk("instant down", 32'd5, {27'h0, drive.level});
    standstill <= 1'b0;
    wait_lvl(5'd20, 3, t);
    chk("instant up", 32'd20, {27'h0, drive.level});
    // zero standstill level under voltage pwm
    bus(1'b1, 8'h40, 32'h00001400);
    pwmMode <= 1'b1;
    standstill <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk("freewheel", 32'h2, {30'h0, drive.freewheel, drive.shortCoils});
    bus(1'b1, 8'h78, 32'h1);
    bus(1'b0, 8'h78, 32'h0);
    chk("ctrl rb", 32'h1, rd);
    repeat (3) @(posedge core_clk);
    chk("short", 32'h1, {30'h0, drive.freewheel, drive.shortCoils});
    pwmMode <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("no pwm", 32'h0, {30'h0, drive.freewheel, drive.shortCoils});
    // enable low freezes everything, even a motion start
    ce <= 1'b0;
    standstill <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("frozen", 32'd0, {27'h0, drive.level});
    ce <= 1'b1;
    wait_lvl(5'd20, 3, t);
    chk("thawed", 32'd20, {27'h0, drive.level});
    print_verdict();
  end
endmodule : testbench
